/* File: core/swl_pkg.sv */
// Shared constants, types and CRC helper for the single-wire identity link
package swl_pkg;

  // ==========================================================================
  // Identity layout
  localparam int ID_W   = 64;
  localparam int FAM_W  = 8;
  localparam int SER_W  = 48;
  localparam int CRC_W  = 8;
  localparam int DATA_W = FAM_W + SER_W;
  localparam int CMD_W  = 8;
  localparam int CNT_W  = 7;

  // ==========================================================================
  // CRC: x^8 + x^5 + x^4 + 1, right-shifting form
  localparam logic [CRC_W-1:0] CRC_POLY = 8'h8c;
  localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;

  // ==========================================================================
  // Identity command codes
  localparam logic [CMD_W-1:0] CMD_READ_ID   = 8'h01;
  localparam logic [CMD_W-1:0] CMD_MATCH_ID  = 8'h02;
  localparam logic [CMD_W-1:0] CMD_SEARCH_ID = 8'h03;
  localparam logic [CMD_W-1:0] CMD_SKIP_ID   = 8'h04;

  // ==========================================================================
  // Search slot phases and function buffer
  localparam logic [1:0] PH_BIT   = 2'h0;
  localparam logic [1:0] PH_COMP  = 2'h1;
  localparam logic [1:0] PH_WRITE = 2'h2;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [1:0] {OP_READ, OP_MATCH, OP_SEARCH, OP_SKIP} rom_op_t;

  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = (c >> 1) ^ (fb ? CRC_POLY : CRC_INIT);
  endfunction

  function automatic logic [CMD_W-1:0] op_code(input rom_op_t op);
    case (op)
      OP_READ:   op_code = CMD_READ_ID;
      OP_MATCH:  op_code = CMD_MATCH_ID;
      OP_SEARCH: op_code = CMD_SEARCH_ID;
      default:   op_code = CMD_SKIP_ID;
    endcase
  endfunction

endpackage

/* File: core/swl_if.sv */
// Slot-level single data line between bus master and identity device
`timescale 1ns/1ps
interface swl_if;
  logic line_reset;
  logic slot;
  logic m_wr;
  logic m_bit;
  logic vpp;
  logic d_bit;
  logic d_oe;
  logic line_level;

  // Open-drain line: device pulls low only when it drives a zero
  assign line_level = (slot & m_wr) ? m_bit : ~(d_oe & ~d_bit);

  modport dev (input line_reset, slot, m_wr, m_bit, vpp,
               output d_bit, d_oe);
  modport mst (output line_reset, slot, m_wr, m_bit, vpp,
               input d_bit, d_oe);
endinterface

/* File: core/swl_device.sv */
// Identity device end: identity ROM, CRC, command gating, function buffer
// Behaviour
// - Identity is family, 48-bit serial, CRC byte
// - Master opens with one of four identity commands
// - No memory function before identity command succeeds
// - After success exactly one function command taken
// - Read, match, search single out devices; skip addresses every device
// - All line bits travel LSB first
// - CRC polynomial x^8+x^5+x^4+1, bit-serial
// - CRC starts zero, family first then serial
// - After serial, accumulator holds stored CRC byte
// - Checker sees all zeros after CRC bits
// - Flag shows programming voltage on line
// - Programming only clears ones to zeros
`timescale 1ns/1ps
module swl_device
  import swl_pkg::*;
#(
  parameter logic [FAM_W-1:0] FAMILY = 8'h5a,          // Arbitrary value
  parameter logic [SER_W-1:0] SERIAL = 48'h0123_4567_89ab
) (
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  swl_if.dev                    link,
  output logic                  o_access,
  output logic                  o_id_ready,
  output logic                  o_fn_valid,
  output logic [CMD_W-1:0]      o_fn_cmd,
  input  wire logic             i_fn_ready,
  output logic                  o_prog_voltage,
  input  wire logic             i_prog_strobe,
  input  wire logic [CMD_W-1:0] i_prog_old,
  input  wire logic [CMD_W-1:0] i_prog_new,
  output logic [CMD_W-1:0]      o_prog_word
);

  typedef enum logic [3:0] {
    S_CRC, S_IDLE, S_CMD, S_READ, S_MATCH, S_SEARCH, S_FUNC, S_PUSH,
    S_HOLD, S_DROP
  } dev_state_e_t;

  typedef struct packed {
    dev_state_e_t          state;
    logic [ID_W-1:0]       id;
    logic [ID_W-1:0]       sh;
    logic [CRC_W-1:0]      crc;
    logic [CMD_W-1:0]      rx;
    logic [CNT_W-1:0]      cnt;
    logic [1:0]            ph;
    logic                  ok;
    logic                  access;
    logic                  id_ready;
    logic                  d_bit;
    logic                  d_oe;
    logic                  vpp;
    logic [CMD_W-1:0]      prog_word;
    logic [1:0][CMD_W-1:0] fbuf;
    logic                  wr_ptr;
    logic                  rd_ptr;
    logic [1:0]            count;
    logic                  fn_valid;
    logic [CMD_W-1:0]      fn_cmd;
  } dev_state_t;

  localparam logic [ID_W-1:0] SEED = {{CRC_W{1'b0}}, SERIAL, FAMILY};

  dev_state_t s_q;
  dev_state_t s_d;

  logic rd_slot;
  logic wr_slot;
  logic last_bit;
  logic pop;

  assign rd_slot  = link.slot & ~link.m_wr;
  assign wr_slot  = link.slot & link.m_wr;
  assign last_bit = (s_q.cnt == CNT_W'(ID_W - 1));
  assign pop      = s_q.fn_valid & i_fn_ready;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.vpp = link.vpp;
    if (i_prog_strobe && s_q.vpp) begin
      s_d.prog_word = i_prog_old & i_prog_new;
    end
    if (pop) begin
      s_d.rd_ptr = ~s_q.rd_ptr;
      s_d.count  = s_q.count - 2'h1;
    end
    if (link.line_reset && s_q.state != S_CRC) begin
      s_d.state  = S_CMD;
      s_d.access = 1'b0;
      s_d.cnt    = '0;
      s_d.rx     = '0;
    end else begin
      case (s_q.state)
        S_CRC: begin
          // Identity CRC is built once after reset, one bit per cycle
          s_d.crc = crc_step(s_q.crc, s_q.sh[0]);
          s_d.sh  = s_q.sh >> 1;
          s_d.cnt = s_q.cnt + CNT_W'(1);
          if (s_q.cnt == CNT_W'(DATA_W - 1)) begin
            s_d.id = {s_d.crc, SEED[DATA_W-1:0]};
            s_d.id_ready = 1'b1;
            s_d.state = S_IDLE;
          end
        end
        S_CMD: begin
          if (wr_slot) begin
            s_d.rx  = {link.m_bit, s_q.rx[CMD_W-1:1]};
            s_d.cnt = s_q.cnt + CNT_W'(1);
            if (s_q.cnt == CNT_W'(CMD_W - 1)) begin
              s_d.cnt = '0;
              s_d.sh  = s_q.id;
              s_d.ph  = PH_BIT;
              s_d.ok  = 1'b1;
              // Unknown commands park the device until the next reset
              if (s_d.rx == CMD_READ_ID) begin
                s_d.state = S_READ;
              end else if (s_d.rx == CMD_MATCH_ID) begin
                s_d.state = S_MATCH;
              end else if (s_d.rx == CMD_SEARCH_ID) begin
                s_d.state = S_SEARCH;
              end else if (s_d.rx == CMD_SKIP_ID) begin
                s_d.state  = S_FUNC;
                s_d.access = 1'b1;
              end else begin
                s_d.state = S_DROP;
              end
            end
          end
        end
        S_READ: begin
          if (rd_slot) begin
            s_d.sh  = s_q.sh >> 1;
            s_d.cnt = s_q.cnt + CNT_W'(1);
            if (last_bit) begin
              s_d.cnt    = '0;
              s_d.state  = S_FUNC;
              s_d.access = 1'b1;
            end
          end
        end
        S_MATCH: begin
          if (wr_slot) begin
            s_d.ok  = s_q.ok & (link.m_bit == s_q.sh[0]);
            s_d.sh  = s_q.sh >> 1;
            s_d.cnt = s_q.cnt + CNT_W'(1);
            if (last_bit) begin
              s_d.cnt    = '0;
              s_d.state  = s_d.ok ? S_FUNC : S_DROP;
              s_d.access = s_d.ok;
            end
          end
        end
        S_SEARCH: begin
          if (rd_slot && s_q.ph != PH_WRITE) begin
            s_d.ph = (s_q.ph == PH_BIT) ? PH_COMP : PH_WRITE;
          end else if (wr_slot && s_q.ph == PH_WRITE) begin
            s_d.ph  = PH_BIT;
            s_d.sh  = s_q.sh >> 1;
            s_d.cnt = s_q.cnt + CNT_W'(1);
            if (link.m_bit != s_q.sh[0]) begin
              s_d.state = S_DROP;
            end else if (last_bit) begin
              s_d.cnt    = '0;
              s_d.state  = S_FUNC;
              s_d.access = 1'b1;
            end
          end
        end
        S_FUNC: begin
          if (wr_slot && s_q.access) begin
            s_d.rx  = {link.m_bit, s_q.rx[CMD_W-1:1]};
            s_d.cnt = s_q.cnt + CNT_W'(1);
            if (s_q.cnt == CNT_W'(CMD_W - 1)) begin
              s_d.state = S_PUSH;
            end
          end
        end
        S_PUSH: begin
          // Holds the byte while the buffer is full; a line reset in this state drops it
          if (s_d.count < BUF_DEPTH) begin
            s_d.fbuf[s_q.wr_ptr] = s_q.rx;
            s_d.wr_ptr = ~s_q.wr_ptr;
            s_d.count  = s_d.count + 2'h1;
            s_d.state  = S_HOLD;
          end
        end
        default: begin
          s_d.state = s_q.state;
        end
      endcase
    end
    s_d.fn_valid = (s_d.count != 2'h0);
    s_d.fn_cmd   = s_d.fbuf[s_d.rd_ptr];
    s_d.d_bit    = (s_d.ph == PH_COMP) ? ~s_d.sh[0] : s_d.sh[0];
    s_d.d_oe     = (s_d.state == S_READ) ||
                   (s_d.state == S_SEARCH && s_d.ph != PH_WRITE);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q       <= '0;
      s_q.state <= S_CRC;
      s_q.sh    <= SEED;
      s_q.crc   <= CRC_INIT;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign link.d_bit     = s_q.d_bit;
  assign link.d_oe      = s_q.d_oe;
  assign o_access       = s_q.access;
  assign o_id_ready     = s_q.id_ready;
  assign o_fn_valid     = s_q.fn_valid;
  assign o_fn_cmd       = s_q.fn_cmd;
  assign o_prog_voltage = s_q.vpp;
  assign o_prog_word    = s_q.prog_word;

endmodule // swl_device

/* File: core/swl_master.sv */
// Bus master end: issues identity command, identity phase, function command
`timescale 1ns/1ps
module swl_master
  import swl_pkg::*;
(
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  swl_if.mst                    link,
  input  wire logic             i_req_valid,
  output logic                  o_req_ready,
  input  wire rom_op_t          i_req_op,
  input  wire logic [ID_W-1:0]  i_rom_id,
  input  wire logic [ID_W-1:0]  i_search_dir,
  input  wire logic [CMD_W-1:0] i_fn_cmd,
  input  wire logic             i_prog_voltage,
  output logic                  o_done,
  output logic                  o_found,
  output logic                  o_crc_ok,
  output logic [ID_W-1:0]       o_rom
);

  typedef enum logic [2:0] {
    H_IDLE, H_RST, H_CMD, H_READ, H_MATCH, H_SEARCH, H_FN
  } mst_state_e_t;

  typedef struct packed {
    mst_state_e_t     state;
    rom_op_t          op;
    logic [ID_W-1:0]  tx;
    logic [ID_W-1:0]  rom;
    logic [ID_W-1:0]  dir;
    logic [CMD_W-1:0] fn;
    logic [CRC_W-1:0] crc;
    logic [CNT_W-1:0] cnt;
    logic [1:0]       ph;
    logic             first;
    logic             line_reset;
    logic             slot;
    logic             m_wr;
    logic             m_bit;
    logic             vpp;
    logic             ready;
    logic             done;
    logic             found;
    logic             crc_ok;
  } mst_state_t;

  mst_state_t s_q;
  mst_state_t s_d;

  logic last_cmd;
  logic last_id;

  assign last_cmd = (s_q.cnt == CNT_W'(CMD_W - 1));
  assign last_id  = (s_q.cnt == CNT_W'(ID_W - 1));

  // ==========================================================================
  // Next state: one slot every second cycle, result taken in the slot cycle
  always_comb begin
    s_d = s_q;
    s_d.vpp        = i_prog_voltage;
    s_d.line_reset = 1'b0;
    s_d.slot       = 1'b0;
    s_d.done       = 1'b0;
    case (s_q.state)
      H_IDLE: begin
        if (i_req_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.op    = i_req_op;
          s_d.dir   = i_search_dir;
          s_d.fn    = i_fn_cmd;
          s_d.tx    = {{(ID_W-CMD_W){1'b0}}, op_code(i_req_op)};
          s_d.state = H_RST;
        end
      end
      H_RST: begin
        s_d.line_reset = 1'b1;
        s_d.cnt   = '0;
        s_d.crc   = CRC_INIT;
        s_d.found = 1'b0;
        s_d.first = 1'b1;
        s_d.state = H_CMD;
      end
      default: begin
        if (s_q.slot || s_q.first) begin
          s_d.first = 1'b0;
          s_d.cnt   = s_q.first ? s_q.cnt : s_q.cnt + CNT_W'(1);
          if (s_q.slot && !s_q.m_wr) begin
            if (s_q.state == H_SEARCH && s_q.ph == PH_BIT) begin
              s_d.m_bit = link.d_bit;
              s_d.ph    = PH_COMP;
              s_d.cnt   = s_q.cnt;
            end else if (s_q.state == H_SEARCH) begin
              s_d.cnt = s_q.cnt;
              s_d.ph  = PH_WRITE;
              if (s_q.m_bit && link.d_bit) begin
                s_d.state = H_IDLE;
                s_d.ready = 1'b1;
                s_d.done  = 1'b1;
              end else if (s_q.m_bit == link.d_bit) begin
                s_d.m_bit = s_q.dir[s_q.cnt[5:0]];
              end
            end else begin
              s_d.rom = {link.d_bit, s_q.rom[ID_W-1:1]};
              s_d.crc = crc_step(s_q.crc, link.d_bit);
            end
          end else if (s_q.slot && s_q.state == H_SEARCH) begin
            s_d.rom = {s_q.m_bit, s_q.rom[ID_W-1:1]};
            s_d.crc = crc_step(s_q.crc, s_q.m_bit);
            s_d.ph  = PH_BIT;
          end
          if (s_q.state == H_CMD && last_cmd && !s_q.first) begin
            s_d.cnt = '0;
            s_d.ph  = PH_BIT;
            s_d.tx  = i_rom_id;
            s_d.first = 1'b1;
            case (s_q.op)
              OP_READ:   s_d.state = H_READ;
              OP_MATCH:  s_d.state = H_MATCH;
              OP_SEARCH: s_d.state = H_SEARCH;
              default:   s_d.state = H_FN;
            endcase
            if (s_q.op == OP_MATCH) begin
              s_d.rom = i_rom_id;
            end
            if (s_q.op == OP_SKIP) begin
              s_d.tx = {{(ID_W-CMD_W){1'b0}}, s_q.fn};
            end
          end else if (s_q.state != H_CMD && s_q.state != H_FN &&
                       last_id && !s_q.first && s_d.ph == PH_BIT) begin
            s_d.cnt   = '0;
            s_d.first = 1'b1;
            s_d.found = 1'b1;
            s_d.crc_ok = (s_d.crc == CRC_INIT);
            s_d.tx    = {{(ID_W-CMD_W){1'b0}}, s_q.fn};
            s_d.state = H_FN;
          end else if (s_q.state == H_FN && last_cmd && !s_q.first) begin
            s_d.state = H_IDLE;
            s_d.ready = 1'b1;
            s_d.done  = 1'b1;
          end
        end else begin
          // Gap cycle: launch the next slot
          s_d.slot = 1'b1;
          s_d.m_wr = (s_q.state == H_CMD) || (s_q.state == H_MATCH) ||
                     (s_q.state == H_FN) ||
                     (s_q.state == H_SEARCH && s_q.ph == PH_WRITE);
          if (s_q.state != H_SEARCH) begin
            s_d.m_bit = s_q.tx[0];
            s_d.tx    = s_q.tx >> 1;
          end
        end
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q       <= '0;
      s_q.state <= H_IDLE;
      s_q.ready <= 1'b1;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign link.line_reset = s_q.line_reset;
  assign link.slot       = s_q.slot;
  assign link.m_wr       = s_q.m_wr;
  assign link.m_bit      = s_q.m_bit;
  assign link.vpp        = s_q.vpp;
  assign o_req_ready     = s_q.ready;
  assign o_done          = s_q.done;
  assign o_found         = s_q.found;
  assign o_crc_ok        = s_q.crc_ok;
  assign o_rom           = s_q.rom;

endmodule // swl_master

/* File: test/swl_props.sv */
// Wire-level checks on the single data line between the two ends
`timescale 1ns/1ps
module swl_props
  import swl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic line_reset,
  input wire logic slot,
  input wire logic m_wr,
  input wire logic m_bit,
  input wire logic vpp,
  input wire logic d_bit,
  input wire logic d_oe,
  input wire logic line_level
);
  // ==========================================================================
  // Slot counter and command decode since the last line reset
  typedef struct packed {
    logic [7:0]       scnt;
    logic [CMD_W-1:0] cmd;
  } mon_t;
  mon_t st_q;
  mon_t st_d;

  always_comb begin
    st_d = st_q;
    if (line_reset) begin
      st_d = '0;
    end else if (slot) begin
      if (st_q.scnt < 8'h08 && m_wr) begin
        st_d.cmd = {m_bit, st_q.cmd[CMD_W-1:1]};
      end
      // Saturate so a runaway master still trips the budget check
      if (st_q.scnt != 8'hff) begin
        st_d.scnt = st_q.scnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_slot_single: assert property (slot |=> !slot)
    else $error("slot held longer than one cycle");
  a_reset_quiet: assert property (line_reset |-> !slot ##1 !slot)
    else $error("slot too close to line reset");
  a_reset_pulse: assert property (line_reset |=> !line_reset)
    else $error("line reset not a single pulse");
  a_cmd_written: assert property (slot && st_q.scnt < 8'h08 |-> m_wr)
    else $error("command slot is not a write");
  a_id_reads: assert property (slot && st_q.cmd == CMD_READ_ID
    && st_q.scnt >= 8'h08 && st_q.scnt < 8'h48 |-> !m_wr)
    else $error("identity read slot is not a read");
  a_match_writes: assert property (slot && st_q.cmd == CMD_MATCH_ID
    && st_q.scnt >= 8'h08 && st_q.scnt < 8'h50 |-> m_wr)
    else $error("match slot is not a write");
  a_skip_writes: assert property (slot && st_q.cmd == CMD_SKIP_ID
    && st_q.scnt >= 8'h08 |-> m_wr)
    else $error("skip phase slot is not a write");
  a_search_triplet: assert property (slot && st_q.cmd == CMD_SEARCH_ID
    && st_q.scnt >= 8'h08 && st_q.scnt < 8'hc8
    |-> m_wr == ((st_q.scnt - 8'h08) % 8'h03 == 8'h02))
    else $error("search slot order broken");
  a_read_bit_held: assert property (slot && !m_wr |-> $stable(d_bit))
    else $error("device bit changed in its read slot");
  a_read_level: assert property (slot && !m_wr
    |-> d_oe && line_level == d_bit)
    else $error("device not driving its read slot");
  a_slot_budget: assert property (slot |-> st_q.scnt < 8'hd0)
    else $error("too many slots after line reset");

  c_read_slot: cover property (slot && !m_wr && d_oe);
  c_search: cover property (slot && st_q.cmd == CMD_SEARCH_ID);
  c_reset: cover property (line_reset);
  c_vpp: cover property (vpp);
endmodule // swl_props

/* File: test/testbench.sv */
// Self-checking bench: master and device joined over the single data line
`timescale 1ns/1ps
module testbench;
  import swl_pkg::*;
  localparam logic [FAM_W-1:0] FAM = 8'h3b;             // Arbitrary value
  localparam logic [SER_W-1:0] SER = 48'ha5c3_0f12_7e69; // Arbitrary value
  logic i_clock, i_rstn, req_valid, req_ready, prog_v, done, found, crc_ok;
  logic access, id_ready, fn_valid, fn_ready, dev_vpp, prog_strobe;
  logic bad_access, bad_id_ready, bad_fn_valid, ce;
  rom_op_t req_op;
  logic [ID_W-1:0] rom_id, search_dir, rom, exp_id;
  logic [CMD_W-1:0] fn_cmd, fn_out, prog_old, prog_new, prog_word;
  int errors, samples_checked, cycles;

  swl_if link_if();
  swl_if bad_if();

  swl_master u_swl_master (.i_clock(i_clock), .i_rstn(i_rstn), .i_ce(ce),
    .link(link_if), .i_req_valid(req_valid), .o_req_ready(req_ready),
    .i_req_op(req_op), .i_rom_id(rom_id), .i_search_dir(search_dir),
    .i_fn_cmd(fn_cmd), .i_prog_voltage(prog_v), .o_done(done),
    .o_found(found), .o_crc_ok(crc_ok), .o_rom(rom));
  swl_device #(.FAMILY(FAM), .SERIAL(SER)) u_swl_device (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(ce), .link(link_if),
    .o_access(access), .o_id_ready(id_ready), .o_fn_valid(fn_valid),
    .o_fn_cmd(fn_out), .i_fn_ready(fn_ready), .o_prog_voltage(dev_vpp),
    .i_prog_strobe(prog_strobe), .i_prog_old(prog_old),
    .i_prog_new(prog_new), .o_prog_word(prog_word));
  // Second device faces a bench driver that sends an unknown command
  swl_device #(.FAMILY(FAM), .SERIAL(SER)) u_swl_device_bad (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(1'b1), .link(bad_if),
    .o_access(bad_access), .o_id_ready(bad_id_ready),
    .o_fn_valid(bad_fn_valid), .o_fn_cmd(), .i_fn_ready(1'b0),
    .o_prog_voltage(), .i_prog_strobe(prog_strobe), .i_prog_old(prog_old),
    .i_prog_new(prog_new), .o_prog_word());
  swl_props u_swl_props (.i_clock(i_clock), .i_rstn(i_rstn),
    .line_reset(link_if.line_reset), .slot(link_if.slot),
    .m_wr(link_if.m_wr), .m_bit(link_if.m_bit), .vpp(link_if.vpp),
    .d_bit(link_if.d_bit), .d_oe(link_if.d_oe),
    .line_level(link_if.line_level));

  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [ID_W-1:0] exp,
                     input logic [ID_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [CRC_W-1:0] crc_of(input logic [DATA_W-1:0] d);
    logic [CRC_W-1:0] c;
    c = 8'h00;
    for (int i = 0; i < DATA_W; i++) begin
      c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
    end
    return c;
  endfunction

  task automatic request(input rom_op_t op, input logic [ID_W-1:0] id,
                         input logic [CMD_W-1:0] fn);
    int n;
    n = 0;
    @(negedge i_clock);
    req_op = op;
    rom_id = id;
    fn_cmd = fn;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge i_clock);
      n++;
    end
    @(negedge i_clock);
    req_valid = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge i_clock);
      n++;
    end
    chk("done", 64'h1, 64'(done));
  endtask

  task automatic pop(input logic [CMD_W-1:0] exp);
    int n;
    n = 0;
    while (fn_valid !== 1'b1 && n < 50) begin
      @(negedge i_clock);
      n++;
    end
    chk("fn_cmd", 64'(exp), 64'(fn_out));
    fn_ready = 1'b1;
    @(negedge i_clock);
    fn_ready = 1'b0;
  endtask

  task automatic bad_send(input logic [CMD_W-1:0] v);
    for (int i = 0; i < CMD_W; i++) begin
      @(negedge i_clock);
      bad_if.slot = 1'b1;
      bad_if.m_bit = v[i];
      @(negedge i_clock);
      bad_if.slot = 1'b0;
      // Released data shows the inverse, not the last bit
      bad_if.m_bit = ~v[i];
    end
  endtask

  // ==========================================================================
  // Clock, timeout and main sequence
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("wrong value timeout expected 0 seen %0d", cycles);
      stop_test();
    end
  end

  initial begin
    {errors, samples_checked, cycles} = '0;
    {req_valid, prog_v, fn_ready, prog_strobe} = '0;
    ce = 1'b1;
    {prog_old, prog_new, fn_cmd} = '0;
    {rom_id, search_dir} = '0;
    req_op = OP_READ;
    {bad_if.line_reset, bad_if.slot, bad_if.m_bit, bad_if.vpp} = '0;
    bad_if.m_wr = 1'b1;
    exp_id = {crc_of({SER, FAM}), SER, FAM};
    i_rstn = 1'b0;
    repeat (20) @(posedge i_clock);
    @(negedge i_clock);
    i_rstn = 1'b1;
    repeat (100) @(negedge i_clock);
    chk("id_ready", 64'h1, 64'(id_ready & bad_id_ready));
    chk("access", 64'h0, 64'(access));
    request(OP_READ, '0, 8'hf0);
    chk("rom", exp_id, rom);
    chk("crc_ok", 64'h1, 64'(crc_ok));
    chk("access", 64'h1, 64'(access));
    // Receiver stalls while three bytes arrive: the third must wait
    request(OP_SKIP, '0, 8'h55);
    request(OP_MATCH, exp_id, 8'haa);
    pop(8'hf0);
    pop(8'h55);
    pop(8'haa);
    chk("fn_valid", 64'h0, 64'(fn_valid));
    request(OP_SEARCH, '0, 8'h22);
    chk("search rom", exp_id, rom);
    chk("found", 64'h1, 64'(found & crc_ok));
    pop(8'h22);
    request(OP_MATCH, exp_id ^ (64'h1 << 40), 8'h11);
    repeat (20) @(negedge i_clock);
    chk("access", 64'h0, 64'(access));
    chk("fn_valid", 64'h0, 64'(fn_valid));
    prog_v = 1'b1;
    repeat (4) @(negedge i_clock);
    chk("prog_voltage", 64'h1, 64'(dev_vpp));
    {prog_strobe, prog_old, prog_new} = {1'b1, 8'hf0, 8'h3c};
    @(negedge i_clock);
    prog_strobe = 1'b0;
    chk("prog_word", 64'h30, 64'(prog_word));
    // Clock enable low must freeze the merge even with the strobe up
    ce = 1'b0;
    {prog_strobe, prog_old, prog_new} = {1'b1, 8'h0f, 8'h0f};
    @(negedge i_clock);
    {prog_strobe, ce} = 2'b01;
    chk("prog_word frozen", 64'h30, 64'(prog_word));
    prog_v = 1'b0;
    repeat (4) @(negedge i_clock);
    {prog_strobe, prog_old, prog_new} = {1'b1, 8'hff, 8'hff};
    @(negedge i_clock);
    prog_strobe = 1'b0;
    chk("prog_word", 64'h30, 64'(prog_word));
    @(negedge i_clock);
    bad_if.line_reset = 1'b1;
    @(negedge i_clock);
    bad_if.line_reset = 1'b0;
    @(negedge i_clock);
    bad_send(8'h77);
    bad_send(8'h99);
    repeat (10) @(negedge i_clock);
    chk("bad access", 64'h0, 64'(bad_access | bad_fn_valid));
    stop_test();
  end
endmodule // testbench
